// File: ahp_byte_if.sv
// byte stream carrier between the parser and its serial ends
interface ahp_byte_if;
	logic       valid;
	logic       ready;
	logic [7:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : ahp_byte_if

// File: ahp_host_model.sv
// host-side model: sends ascii frames on rxd and collects reply characters from txd
module ahp_host_model #(
	parameter int unsigned BIT_CYCLES = 16,
	parameter int unsigned GAP_CYC    = 2
) (
	input  wire logic clk_sys,
	input  wire logic txd,
	output var  logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	import ahp_pkg::*;

	// =====================================================================
	// transmit side
	logic [7:0] rx_q[$];

	initial rxd = 1'h1;

	task automatic bit_time();
		repeat (BIT_CYCLES) @(posedge clk_sys);
		#1;
	endtask : bit_time

	task automatic send_chr(input logic [7:0] c);
		@(posedge clk_sys);
		#1;
		rxd = 1'h0;
		bit_time();
		for (int i = 0; i < 8; i++) begin
			rxd = c[i];
			bit_time();
		end
		rxd = 1'h1;
		bit_time();
		// pause between characters; the parser needs none, so keep it short
		repeat (GAP_CYC) @(posedge clk_sys);
	endtask : send_chr

	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++) begin
			send_chr(s[i]);
		end
	endtask : send_str

	// =====================================================================
	// receive side: mid-bit sampling; a bad stop bit is logged as ff
	always begin : rx_loop
		logic [7:0] b;
		@(negedge txd);
		repeat (BIT_CYCLES / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clk_sys);
			b[i] = txd;
		end
		repeat (BIT_CYCLES) @(posedge clk_sys);
		if (txd !== 1'h1) begin
			b = 8'hFF;
		end
		rx_q.push_back(b);
	end

endmodule : ahp_host_model

// File: ahp_parser.sv
// ascii-hex command frame parser: station check, checksum and framed reply
// =========================================================================
module ahp_parser #(
	parameter int unsigned BIT_CYCLES = ahp_pkg::BIT_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        rxd,
	output wire logic        txd,
	output wire logic        cmd_valid,
	output wire logic [7:0]  cmd_code,
	output wire logic [31:0] cmd_value,
	output wire logic        sum_err,
	input  wire logic        rsp_valid,
	input  wire logic        rsp_write,
	input  wire logic [31:0] rsp_value
);
	import ahp_pkg::*;

	logic          rxd_m_r;
	logic          rxd_s_r;
	ahp_state_type state_r;
	logic [3:0]    idx_r;
	logic [7:0]    sum_r;
	logic [7:0]    rx_sum_r;
	logic [7:0]    code_r;
	logic [15:0]   addr_r;
	logic [31:0]   val_r;
	logic          bad_r;
	logic [31:0]   rep_val_r;
	logic          rep_err_r;
	logic [3:0]    rep_idx_r;
	logic          tx_valid_r;
	logic [7:0]    tx_data_r;
	logic          cmd_valid_r;
	logic [7:0]    cmd_code_r;
	logic [31:0]   cmd_value_r;
	logic          sum_err_r;
	logic          rx_fire;
	logic          got_start;
	logic          in_frame;
	logic          eval;
	logic          addr_ok;
	logic          sum_ok;
	logic          tx_take;
	logic [4:0]    hv;
	logic [7:0]    rep_sum;
	logic [7:0]    out_sum;
	logic [31:0]   rep_shv;
	logic [7:0]    rep_chr;

	ahp_byte_if rx_bus ();
	ahp_byte_if tx_bus ();

	function automatic logic [7:0] val_sum(input logic [31:0] v);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < VAL_CHARS; i++) begin
			s = 8'(s + hex_chr(v[4*i +: 4]));
		end
		return s;
	endfunction : val_sum

	// =========================================================================
	// serial ends
	always_ff @(posedge clk_sys or negedge rstn) begin : sync
		if (!rstn) begin
			rxd_m_r <= 1'b1;
			rxd_s_r <= 1'b1;
		end else begin
			rxd_m_r <= rxd;
			rxd_s_r <= rxd_m_r;
		end
	end

	ahp_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.rxd_s   (rxd_s_r),
		.out     (rx_bus)
	);

	ahp_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.in      (tx_bus),
		.txd     (txd)
	);

	// the parser absorbs a character every cycle, so no back-pressure
	assign rx_bus.ready = 1'b1;

	// =========================================================================
	// frame reception
	assign rx_fire   = rx_bus.valid && rx_bus.ready;
	assign got_start = rx_fire && rx_bus.data == CHR_START;
	assign in_frame  = rx_fire && state_r == ST_RECV;
	assign hv        = hex_val(rx_bus.data);
	assign eval      = in_frame && idx_r == POS_CR && rx_bus.data == CHR_CR;
	assign addr_ok   = addr_r == STATION;
	assign sum_ok    = !bad_r && rx_sum_r == sum_r;

	always_ff @(posedge clk_sys or negedge rstn) begin : capture
		if (!rstn) begin
			idx_r    <= 4'h0;
			sum_r    <= 8'h00;
			bad_r    <= 1'b0;
			addr_r   <= 16'h0000;
			code_r   <= 8'h00;
			val_r    <= 32'h00000000;
			rx_sum_r <= 8'h00;
		end else if (got_start) begin
			idx_r <= 4'h0;
			sum_r <= 8'h00;
			bad_r <= 1'b0;
		end else if (in_frame && idx_r != POS_CR) begin
			idx_r <= idx_r + 4'h1;
			if (idx_r < POS_SUM) begin
				sum_r <= 8'(sum_r + rx_bus.data);
			end
			if (idx_r >= POS_CMD && !hv[4]) begin
				bad_r <= 1'b1;
			end
			if (idx_r < POS_CMD) begin
				addr_r <= {addr_r[7:0], rx_bus.data};
			end else if (idx_r < POS_VAL) begin
				code_r <= {code_r[3:0], hv[3:0]};
			end else if (idx_r < POS_SUM) begin
				val_r <= {val_r[27:0], hv[3:0]};
			end else begin
				rx_sum_r <= {rx_sum_r[3:0], hv[3:0]};
			end
		end
	end

	// =========================================================================
	// sequencing
	always_ff @(posedge clk_sys or negedge rstn) begin : fsm
		if (!rstn) begin
			state_r <= ST_HUNT;
		end else if (got_start) begin
			state_r <= ST_RECV;
		end else begin
			unique case (state_r)
				ST_HUNT: begin
					state_r <= ST_HUNT;
				end
				ST_RECV: begin
					if (eval) begin
						// other stations stay silent, even on a bad checksum
						state_r <= !addr_ok ? ST_HUNT : (sum_ok ? ST_WAIT : ST_SEND);
					end else if (in_frame && (idx_r == POS_CR || rx_bus.data == CHR_CR)) begin
						state_r <= ST_HUNT;
					end
				end
				ST_WAIT: begin
					if (rsp_valid) begin
						state_r <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (tx_take && rep_idx_r == REP_LAST) begin
						state_r <= ST_HUNT;
					end
				end
			endcase
		end
	end

	// =========================================================================
	// command hand-off
	always_ff @(posedge clk_sys or negedge rstn) begin : command
		if (!rstn) begin
			cmd_valid_r <= 1'b0;
			cmd_code_r  <= 8'h00;
			cmd_value_r <= 32'h00000000;
			sum_err_r   <= 1'b0;
		end else begin
			cmd_valid_r <= eval && addr_ok && sum_ok;
			sum_err_r   <= eval && addr_ok && !sum_ok;
			if (eval && addr_ok && sum_ok) begin
				cmd_code_r  <= code_r;
				cmd_value_r <= val_r;
			end
		end
	end

	assign cmd_valid = cmd_valid_r;
	assign cmd_code  = cmd_code_r;
	assign cmd_value = cmd_value_r;
	assign sum_err   = sum_err_r;

	// =========================================================================
	// reply
	always_ff @(posedge clk_sys or negedge rstn) begin : reply
		if (!rstn) begin
			rep_val_r <= 32'h00000000;
			rep_err_r <= 1'b0;
			rep_idx_r <= 4'h0;
		end else if (eval && addr_ok) begin
			rep_err_r <= !sum_ok;
			rep_idx_r <= 4'h0;
		end else if (state_r == ST_WAIT && rsp_valid) begin
			rep_val_r <= rsp_write ? val_r : rsp_value;
		end else if (tx_take) begin
			rep_idx_r <= rep_idx_r + 4'h1;
		end
	end

	assign rep_sum = val_sum(rep_val_r);
	assign out_sum = rep_err_r ? ERR_SUM : rep_sum;
	assign rep_shv = rep_val_r >> {4'(REP_VAL_LO - rep_idx_r), 2'b00};

	always_comb begin
		rep_chr = CHR_ACK;
		if (rep_idx_r == 4'h0) begin
			rep_chr = CHR_START;
		end else if (rep_idx_r < REP_SUM_HI) begin
			rep_chr = rep_err_r ? CHR_X : hex_chr(rep_shv[3:0]);
		end else if (rep_idx_r == REP_SUM_HI) begin
			rep_chr = hex_chr(out_sum[7:4]);
		end else if (rep_idx_r == REP_SUM_LO) begin
			rep_chr = hex_chr(out_sum[3:0]);
		end
	end

	// one character in flight at a time; the tx end stalls us through ready
	assign tx_take = state_r == ST_SEND && !tx_valid_r && tx_bus.ready;

	always_ff @(posedge clk_sys or negedge rstn) begin : tx_feed
		if (!rstn) begin
			tx_valid_r <= 1'b0;
			tx_data_r  <= 8'h00;
		end else begin
			tx_valid_r <= tx_take;
			if (tx_take) begin
				tx_data_r <= rep_chr;
			end
		end
	end

	assign tx_bus.valid = tx_valid_r;
	assign tx_bus.data  = tx_data_r;

	// =========================================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_addr_drop;
		(eval && !addr_ok) |=> (state_r == ST_HUNT && !cmd_valid_r && !sum_err_r);
	endproperty
	a_addr_drop: assert property (p_addr_drop) else $error("foreign station answered");

	property p_sum_cmp;
		(eval && addr_ok && sum_r != rx_sum_r) |=> (sum_err_r && !cmd_valid_r);
	endproperty
	a_sum_cmp: assert property (p_sum_cmp) else $error("checksum mismatch not flagged");

	property p_err_reply;
		sum_err_r |-> (state_r == ST_SEND && rep_err_r && rep_idx_r == 4'h0);
	endproperty
	a_err_reply: assert property (p_err_reply) else $error("error reply not started");

	property p_err_char;
		(tx_valid_r && rep_err_r && $past(rep_idx_r) == 4'h3) |-> tx_data_r == CHR_X;
	endproperty
	a_err_char: assert property (p_err_char) else $error("error reply lacks X");

	property p_start_chr;
		tx_valid_r |-> (($past(rep_idx_r) == 4'h0) == (tx_data_r == CHR_START));
	endproperty
	a_start_chr: assert property (p_start_chr) else $error("start character misplaced");

	property p_ack_chr;
		(tx_valid_r && $past(rep_idx_r) == REP_LAST) |-> tx_data_r == CHR_ACK;
	endproperty
	a_ack_chr: assert property (p_ack_chr) else $error("reply not ended by acknowledge");

	property p_lower_hex;
		(tx_valid_r && !rep_err_r && $past(rep_idx_r) inside {[4'h1:4'hA]})
			|-> tx_data_r inside {[CHR_DIG0:CHR_DIG9], [CHR_LA:CHR_LF]};
	endproperty
	a_lower_hex: assert property (p_lower_hex) else $error("reply digit not lowercase hex");

	property p_val_msn;
		(tx_valid_r && !rep_err_r && $past(rep_idx_r) == 4'h1)
			|-> tx_data_r == hex_chr(rep_val_r[31:28]);
	endproperty
	a_val_msn: assert property (p_val_msn) else $error("value sent out of order");

	property p_sum_lo;
		(tx_valid_r && !rep_err_r && $past(rep_idx_r) == REP_SUM_LO)
			|-> tx_data_r == hex_chr(4'(val_sum(rep_val_r)));
	endproperty
	a_sum_lo: assert property (p_sum_lo) else $error("reply checksum wrong");

	property p_echo;
		(state_r == ST_WAIT && rsp_valid && rsp_write) |=> rep_val_r == $past(val_r);
	endproperty
	a_echo: assert property (p_echo) else $error("write reply does not echo value");

	property p_query;
		(state_r == ST_WAIT && rsp_valid && !rsp_write) |=> rep_val_r == $past(rsp_value);
	endproperty
	a_query: assert property (p_query) else $error("query reply lost its value");

	property p_restart;
		got_start |=> (state_r == ST_RECV && idx_r == 4'h0 && sum_r == 8'h00);
	endproperty
	a_restart: assert property (p_restart) else $error("new start did not restart");

	c_write: cover property (state_r == ST_WAIT && rsp_valid && rsp_write);
	c_query: cover property (state_r == ST_WAIT && rsp_valid && !rsp_write);
	c_error: cover property (sum_err_r);
	c_drop:  cover property (eval && !addr_ok);

endmodule : ahp_parser

// File: ahp_parser_tb_top.sv
// self-checking testbench of the ascii-hex frame parser
module ahp_parser_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ahp_pkg::*;

	localparam int B    = 16;
	localparam int WAIT = 14 * 10 * B;

	logic        clk_sys;
	logic        rstn;
	logic        rxd;
	logic        txd;
	logic        cmd_valid;
	logic [7:0]  cmd_code;
	logic [31:0] cmd_value;
	logic        sum_err;
	logic        rsp_valid;
	logic        rsp_write;
	logic [31:0] rsp_value;
	int          n_fail;
	int          compares;
	int          n_cmd;
	int          n_err;

	ahp_parser #(.BIT_CYCLES(B)) i_ahp_parser (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.rxd       (rxd),
		.txd       (txd),
		.cmd_valid (cmd_valid),
		.cmd_code  (cmd_code),
		.cmd_value (cmd_value),
		.sum_err   (sum_err),
		.rsp_valid (rsp_valid),
		.rsp_write (rsp_write),
		.rsp_value (rsp_value)
	);

	ahp_host_model #(.BIT_CYCLES(B), .GAP_CYC(2)) i_ahp_host_model (
		.clk_sys (clk_sys),
		.txd     (txd),
		.rxd     (rxd)
	);

	// =====================================================================
	// clock, pulse counters, helpers
	initial clk_sys = 1'h0;
	always #12.5 clk_sys = ~clk_sys;

	// pulses are counted mid-cycle, away from the edge that launches them
	always @(negedge clk_sys) begin
		if (cmd_valid === 1'h1) n_cmd++;
		if (sum_err === 1'h1) n_err++;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	function automatic logic [7:0] hex_d(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h57 + 8'(n);
	endfunction : hex_d

	function automatic logic [7:0] sum_of(input string s);
		logic [7:0] acc;
		acc = 8'h00;
		for (int i = 0; i < s.len(); i++) acc += s[i];
		return acc;
	endfunction : sum_of

	// '*', body, checksum of body (plus a deliberate offset), carriage return
	task automatic send_frame(input string body, input logic [7:0] delta);
		logic [7:0] s;
		s = sum_of(body) + delta;
		i_ahp_host_model.send_str({"*", body});
		i_ahp_host_model.send_chr(hex_d(s[7:4]));
		i_ahp_host_model.send_chr(hex_d(s[3:0]));
		i_ahp_host_model.send_chr(CHR_CR);
	endtask : send_frame

	task automatic wait_pulse(input int c0, input int e0);
		for (int k = 0; k < 200 && n_cmd == c0 && n_err == e0; k++) @(posedge clk_sys);
		#1;
	endtask : wait_pulse

	task automatic answer(input logic wr, input logic [31:0] v);
		@(posedge clk_sys);
		#1;
		rsp_valid = 1'h1;
		rsp_write = wr;
		rsp_value = v;
		@(posedge clk_sys);
		#1;
		rsp_valid = 1'h0;
	endtask : answer

	task automatic expect_value(input string v);
		logic [7:0] s;
		s = sum_of(v);
		for (int k = 0; k < WAIT && i_ahp_host_model.rx_q.size() < 12; k++) @(posedge clk_sys);
		check(i_ahp_host_model.rx_q.size(), 12);
		if (i_ahp_host_model.rx_q.size() >= 12) begin
			check(i_ahp_host_model.rx_q.pop_front(), CHR_START);
			for (int i = 0; i < 8; i++) check(i_ahp_host_model.rx_q.pop_front(), v[i]);
			check(i_ahp_host_model.rx_q.pop_front(), hex_d(s[7:4]));
			check(i_ahp_host_model.rx_q.pop_front(), hex_d(s[3:0]));
			check(i_ahp_host_model.rx_q.pop_front(), CHR_ACK);
		end
		i_ahp_host_model.rx_q.delete();
	endtask : expect_value

	// =====================================================================
	// scenarios
	task automatic sc_write();
		int c0;
		c0 = n_cmd;
		send_frame("001c000003e8", 8'h00);
		wait_pulse(c0, n_err);
		check(n_cmd, c0 + 1);
		check(cmd_code, 8'h1C);
		check(cmd_value, 32'h0000_03E8);
		check(txd, 1'h1);
		answer(1'h1, 32'h0000_0000);
		expect_value("000003e8");
	endtask : sc_write

	task automatic sc_query();
		int c0;
		int e0;
		c0 = n_cmd;
		e0 = n_err;
		send_frame("000100000000", 8'h00);
		wait_pulse(c0, e0);
		check(n_cmd, c0 + 1);
		check(n_err, e0);
		check(cmd_code, 8'h01);
		check(cmd_value, 32'h0000_0000);
		answer(1'h0, 32'h0000_00FA);
		expect_value("000000fa");
	endtask : sc_query

	task automatic sc_negative();
		int c0;
		c0 = n_cmd;
		send_frame("001cffffff6a", 8'h00);
		wait_pulse(c0, n_err);
		check(n_cmd, c0 + 1);
		check(cmd_value, 32'hFFFF_FF6A);
		answer(1'h1, 32'h0000_0000);
		expect_value("ffffff6a");
	endtask : sc_negative

	// a bad checksum and an upper-case digit both earn the fixed error reply
	task automatic sc_error(input string body, input logic [7:0] delta);
		int c0;
		int e0;
		c0 = n_cmd;
		e0 = n_err;
		send_frame(body, delta);
		wait_pulse(c0, e0);
		check(n_err, e0 + 1);
		check(n_cmd, c0);
		expect_value("XXXXXXXX");
	endtask : sc_error

	task automatic sc_address();
		int c0;
		int e0;
		c0 = n_cmd;
		e0 = n_err;
		send_frame("011c000003e8", 8'h00);
		repeat (20 * B) @(posedge clk_sys);
		check(n_cmd, c0);
		check(n_err, e0);
		check(i_ahp_host_model.rx_q.size(), 0);
	endtask : sc_address

	task automatic sc_restart();
		int c0;
		c0 = n_cmd;
		i_ahp_host_model.send_str("*001c0000");
		check(n_cmd, c0);
		send_frame("002900000000", 8'h00);
		wait_pulse(c0, n_err);
		check(n_cmd, c0 + 1);
		check(cmd_code, 8'h29);
		answer(1'h1, 32'h0000_0000);
		expect_value("00000000");
	endtask : sc_restart

	// a frame cut short by an early carriage return is dropped silently
	task automatic sc_short();
		int c0;
		int e0;
		c0 = n_cmd;
		e0 = n_err;
		i_ahp_host_model.send_str("*001c0000");
		i_ahp_host_model.send_chr(CHR_CR);
		repeat (20 * B) @(posedge clk_sys);
		check(n_cmd, c0);
		check(n_err, e0);
		check(i_ahp_host_model.rx_q.size(), 0);
	endtask : sc_short

	// a reset in mid-run clears the held command and leaves the line idle
	task automatic sc_reset();
		@(posedge clk_sys);
		#1;
		rstn = 1'h0;
		repeat (2) @(posedge clk_sys);
		#1;
		check(txd, 1'h1);
		check(cmd_code, 8'h00);
		check(cmd_value, 32'h0000_0000);
		rstn = 1'h1;
		repeat (2) @(posedge clk_sys);
		#1;
		check(txd, 1'h1);
		check(cmd_valid, 1'h0);
	endtask : sc_reset

	// =====================================================================
	// sequence, watchdog, verdict
	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	initial begin
		rstn = 1'h0;
		rsp_valid = 1'h0;
		rsp_write = 1'h0;
		rsp_value = 32'h0000_0000;
		n_fail = 0;
		compares = 0;
		n_cmd = 0;
		n_err = 0;
		repeat (4) @(posedge clk_sys);
		#1;
		check(txd, 1'h1);
		check(cmd_valid, 1'h0);
		rstn = 1'h1;
		sc_write();
		sc_query();
		sc_negative();
		sc_error("001c000003e8", 8'h01);
		sc_error("001c000003E8", 8'h00);
		sc_address();
		sc_short();
		sc_reset();
		sc_restart();
		final_report();
	end

	initial begin
		repeat (50000) @(posedge clk_sys);
		n_fail++;
		final_report();
	end

endmodule : ahp_parser_tb_top

// File: ahp_pkg.sv
// shared constants, state type and hex helpers of the ascii-hex frame parser
package ahp_pkg;

	// =====================================================================
	// link timing
	localparam int unsigned CLK_HZ    = 40_000_000;
	localparam int unsigned BAUD      = 9600;
	localparam int unsigned BIT_CYC   = CLK_HZ / BAUD;
	localparam int unsigned DATA_BITS = 8;
	localparam logic [3:0]  LAST_BIT  = 4'(DATA_BITS + 1);
	typedef logic [15:0] ahp_cnt_type;

	// =====================================================================
	// character codes
	localparam logic [7:0]  CHR_START = 8'h2A;
	localparam logic [7:0]  CHR_CR    = 8'h0D;
	localparam logic [7:0]  CHR_ACK   = 8'h5E;
	localparam logic [7:0]  CHR_X     = 8'h58;
	localparam logic [7:0]  CHR_DIG0  = 8'h30;
	localparam logic [7:0]  CHR_DIG9  = 8'h39;
	localparam logic [7:0]  CHR_LA    = 8'h61;
	localparam logic [7:0]  CHR_LF    = 8'h66;
	localparam logic [7:0]  ERR_SUM   = 8'hC0;
	localparam logic [15:0] STATION   = 16'h3030;

	// =====================================================================
	// frame positions, counted after the start character; reply positions count the start character as 0
	localparam logic [3:0]  POS_CMD    = 4'h2;
	localparam logic [3:0]  POS_VAL    = 4'h4;
	localparam logic [3:0]  POS_SUM    = 4'hC;
	localparam logic [3:0]  POS_CR     = 4'hE;
	localparam int unsigned VAL_CHARS  = 8;
	localparam logic [3:0]  REP_VAL_LO = 4'h8;
	localparam logic [3:0]  REP_SUM_HI = 4'h9;
	localparam logic [3:0]  REP_SUM_LO = 4'hA;
	localparam logic [3:0]  REP_LAST   = 4'hB;

	typedef enum logic [1:0] {ST_HUNT, ST_RECV, ST_WAIT, ST_SEND} ahp_state_type;

	// {ok, nibble}; upper-case letters are not digits here
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= CHR_DIG0 && c <= CHR_DIG9) return {1'b1, c[3:0]};
		if (c >= CHR_LA && c <= CHR_LF) return {1'b1, 4'(c[3:0] + 4'h9)};
		return 5'h00;
	endfunction : hex_val

	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		if (n < 4'hA) return 8'(CHR_DIG0 + {4'h0, n});
		return 8'(CHR_LA + {4'h0, n} - 8'h0A);
	endfunction : hex_chr

endpackage : ahp_pkg

// File: ahp_uart_rx.sv
// serial receiver: start, eight data bits lsb first, one stop bit
module ahp_uart_rx #(
	parameter int unsigned BIT_CYCLES = ahp_pkg::BIT_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic rxd_s,
	ahp_byte_if.src   out
);
	import ahp_pkg::*;

	localparam ahp_cnt_type FULL = ahp_cnt_type'(BIT_CYCLES - 1);
	localparam ahp_cnt_type HALF = ahp_cnt_type'(BIT_CYCLES / 2 - 1);

	logic        busy_r;
	ahp_cnt_type cnt_r;
	logic [3:0]  bit_r;
	logic [7:0]  shf_r;
	logic        valid_r;
	logic [7:0]  data_r;
	logic        stop_ok;

	// =====================================================================
	// bit timing, sampling at mid-bit
	assign stop_ok = busy_r && cnt_r == 16'h0000 && bit_r == LAST_BIT && rxd_s;

	always_ff @(posedge clk_sys or negedge rstn) begin : frame
		if (!rstn) begin
			busy_r <= 1'b0;
			cnt_r  <= 16'h0000;
			bit_r  <= 4'h0;
			shf_r  <= 8'h00;
		end else if (!busy_r) begin
			if (!rxd_s) begin
				busy_r <= 1'b1;
				cnt_r  <= HALF;
				bit_r  <= 4'h0;
			end
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end else begin
			cnt_r <= FULL;
			bit_r <= bit_r + 4'h1;
			// a start edge that is gone by mid-bit was a glitch
			if (bit_r == 4'h0) begin
				busy_r <= !rxd_s;
			end else if (bit_r == LAST_BIT) begin
				busy_r <= 1'b0;
			end else begin
				shf_r <= {rxd_s, shf_r[7:1]};
			end
		end
	end

	// =====================================================================
	// delivery; a byte with a low stop bit is dropped
	always_ff @(posedge clk_sys or negedge rstn) begin : deliver
		if (!rstn) begin
			valid_r <= 1'b0;
			data_r  <= 8'h00;
		end else if (stop_ok) begin
			valid_r <= 1'b1;
			data_r  <= shf_r;
		end else if (out.ready) begin
			valid_r <= 1'b0;
		end
	end

	assign out.valid = valid_r;
	assign out.data  = data_r;

endmodule : ahp_uart_rx

// File: ahp_uart_tx.sv
// serial transmitter: start, eight data bits lsb first, one stop bit
module ahp_uart_tx #(
	parameter int unsigned BIT_CYCLES = ahp_pkg::BIT_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	ahp_byte_if.snk   in,
	output wire logic txd
);
	import ahp_pkg::*;

	localparam ahp_cnt_type FULL = ahp_cnt_type'(BIT_CYCLES - 1);

	ahp_cnt_type cnt_r;
	logic [3:0]  bit_r;
	logic [8:0]  shf_r;
	logic        ready_r;
	logic        txd_r;
	logic [15:0] busy_cnt_r;

	// =====================================================================
	// shifter
	always_ff @(posedge clk_sys or negedge rstn) begin : shift
		if (!rstn) begin
			ready_r <= 1'b1;
			txd_r   <= 1'b1;
			cnt_r   <= 16'h0000;
			bit_r   <= 4'h0;
			shf_r   <= 9'h1FF;
		end else if (ready_r) begin
			if (in.valid) begin
				ready_r <= 1'b0;
				txd_r   <= 1'b0;
				shf_r   <= {1'b1, in.data};
				cnt_r   <= FULL;
				bit_r   <= 4'h0;
			end
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end else begin
			cnt_r <= FULL;
			if (bit_r == LAST_BIT) begin
				ready_r <= 1'b1;
			end else begin
				txd_r <= shf_r[0];
				shf_r <= {1'b1, shf_r[8:1]};
				bit_r <= bit_r + 4'h1;
			end
		end
	end

	assign in.ready = ready_r;
	assign txd      = txd_r;

	// =====================================================================
	// checks
	always_ff @(posedge clk_sys or negedge rstn) begin : busy_count
		if (!rstn) begin
			busy_cnt_r <= 16'h0000;
		end else if (ready_r && in.valid) begin
			busy_cnt_r <= 16'h0000;
		end else if (!ready_r) begin
			busy_cnt_r <= busy_cnt_r + 16'h0001;
		end
	end

	property p_char_time;
		@(posedge clk_sys) disable iff (!rstn)
		$rose(ready_r) |-> busy_cnt_r == 16'(10 * BIT_CYCLES);
	endproperty
	a_char_time: assert property (p_char_time)
		else $error("character did not last ten bit times");

endmodule : ahp_uart_tx
